// ---- src/path_trace_monitor.sv ----
// Path trace monitor: repeats a 64-byte transmit trace and checks the received trace.
// Assumes one J1 slot pulse per frame on each direction, all synchronous to mclk.
//
// Functional notes
// - Trace is 64 bytes, one per frame.
// - Transmit string repeats continuously, wrapping without gaps.
// - Alarm when received string differs from baseline.
// - Automatic mode learns first complete string as baseline.
// - Manual mode compares against operator-written baseline.
`timescale 1ns/1ps
`include "path_trace_defines.svh"

module path_trace_monitor #(
   parameter int FIFO_DEPTH = `RX_FIFO_DEPTH
) (
   input  wire logic                    mclk,
   input  wire logic                    nrst,
   input  wire logic                    tx_cfg_wr,
   input  wire logic [`TRACE_IDX_W-1:0] tx_cfg_addr,
   input  wire logic [7:0]              tx_cfg_data,
   input  wire logic                    tx_slot,
   output logic [7:0]                   tx_byte,
   output logic                         tx_byte_valid,
   input  wire logic                    rx_j1_valid,
   input  wire logic [7:0]              rx_j1_byte,
   output logic                         rx_j1_ready,
   input  wire logic                    manual_mode,
   input  wire logic                    base_wr,
   input  wire logic [`TRACE_IDX_W-1:0] base_addr,
   input  wire logic [7:0]              base_data,
   output logic                         baseline_valid,
   output logic                         trace_mismatch,
   output logic                         string_done
);

   // ------------------------------------------------------------
   // Transmit trace
   // ------------------------------------------------------------
   logic [7:0]              tx_string [`TRACE_LEN];
   logic [`TRACE_IDX_W-1:0] tx_idx;

   always_ff @(posedge mclk)
   begin
      if (tx_cfg_wr)
      begin
         tx_string[tx_cfg_addr] <= tx_cfg_data;
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         tx_idx        <= `TRACE_IDX_ZERO;
         tx_byte       <= 8'h00;
         tx_byte_valid <= 1'b0;
      end
      else
      begin
         tx_byte_valid <= tx_slot;
         if (tx_slot)
         begin
            tx_byte <= tx_string[tx_idx];
            tx_idx  <= tx_idx + `TRACE_IDX_W'(1);
         end
      end
   end

   // ------------------------------------------------------------
   // Receive buffer
   // ------------------------------------------------------------
   logic       fifo_valid;
   logic       fifo_ready;
   logic [7:0] rx_byte;
   logic       pop;

   // A baseline write restarts the comparison, so draining pauses while the operator writes it.
   assign fifo_ready = !base_wr;
   assign pop        = fifo_valid && fifo_ready;

   trace_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) rx_fifo (
      .mclk      (mclk),
      .nrst      (nrst),
      .in_valid  (rx_j1_valid),
      .in_ready  (rx_j1_ready),
      .in_data   (rx_j1_byte),
      .out_valid (fifo_valid),
      .out_ready (fifo_ready),
      .out_data  (rx_byte)
   );

   // ------------------------------------------------------------
   // Baselines
   // ------------------------------------------------------------
   logic [7:0]                 learned   [`TRACE_LEN];
   logic [7:0]                 manual_bl [`TRACE_LEN];
   logic [`TRACE_IDX_W-1:0]    rx_idx;
   path_trace_pkg::rx_state_t  state;
   path_trace_pkg::trace_mode_t mode;
   path_trace_pkg::trace_mode_t mode_q;
   logic                       restart;
   logic [7:0]                 expected;
   logic                       acc;
   logic                       differs;

   assign mode     = manual_mode ? path_trace_pkg::MODE_MANUAL : path_trace_pkg::MODE_AUTO;
   assign restart  = (mode != mode_q) || base_wr;
   assign expected = (mode_q == path_trace_pkg::MODE_MANUAL) ? manual_bl[rx_idx] : learned[rx_idx];
   assign differs  = (rx_byte != expected);

   always_ff @(posedge mclk)
   begin
      if (base_wr)
      begin
         manual_bl[base_addr] <= base_data;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (pop && !restart && state == path_trace_pkg::S_LEARN)
      begin
         learned[rx_idx] <= rx_byte;
      end
   end

   // ------------------------------------------------------------
   // Receive check
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         mode_q         <= path_trace_pkg::MODE_AUTO;
         state          <= path_trace_pkg::S_LEARN;
         rx_idx         <= `TRACE_IDX_ZERO;
         acc            <= 1'b0;
         baseline_valid <= 1'b0;
         trace_mismatch <= 1'b0;
         string_done    <= 1'b0;
      end
      else
      begin
         mode_q      <= mode;
         string_done <= 1'b0;
         if (restart)
         begin
            // A partial string is dropped; in manual mode the next complete one decides the alarm, in automatic mode the alarm clears and it is learned.
            rx_idx <= `TRACE_IDX_ZERO;
            acc    <= 1'b0;
            if (mode == path_trace_pkg::MODE_AUTO)
            begin
               state          <= path_trace_pkg::S_LEARN;
               baseline_valid <= 1'b0;
               trace_mismatch <= 1'b0;
            end
            else
            begin
               state          <= path_trace_pkg::S_CHECK;
               baseline_valid <= 1'b1;
            end
         end
         else if (pop)
         begin
            rx_idx <= rx_idx + `TRACE_IDX_W'(1);
            unique case (state)
               path_trace_pkg::S_LEARN:
               begin
                  if (rx_idx == `TRACE_IDX_LAST)
                  begin
                     state          <= path_trace_pkg::S_CHECK;
                     baseline_valid <= 1'b1;
                  end
               end
               path_trace_pkg::S_CHECK:
               begin
                  if (rx_idx == `TRACE_IDX_LAST)
                  begin
                     trace_mismatch <= acc || differs;
                     string_done    <= 1'b1;
                     acc            <= 1'b0;
                  end
                  else
                  begin
                     acc <= acc || differs;
                  end
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   tx_wrap_a: assert property (tx_slot && tx_idx == `TRACE_IDX_LAST |=> tx_idx == `TRACE_IDX_ZERO)
      else $error("transmit index did not wrap to the first byte");
   tx_byte_a: assert property (tx_slot && !tx_cfg_wr |=> tx_byte_valid && tx_byte == $past(tx_string[tx_idx]))
      else $error("transmit byte not taken from the trace string");
   done_len_a: assert property (string_done |-> $past(pop && rx_idx == `TRACE_IDX_LAST && !restart))
      else $error("string completed at the wrong byte count");
   alarm_val_a: assert property (pop && !restart && state == path_trace_pkg::S_CHECK
      && rx_idx == `TRACE_IDX_LAST |=> trace_mismatch == $past(acc || differs))
      else $error("alarm does not reflect the compared string");
   learn_end_a: assert property (pop && !restart && state == path_trace_pkg::S_LEARN
      && rx_idx == `TRACE_IDX_LAST |=> state == path_trace_pkg::S_CHECK && baseline_valid)
      else $error("automatic baseline not taken after first string");
   manual_chk_a: assert property (mode_q == path_trace_pkg::MODE_MANUAL && !restart
      |-> state == path_trace_pkg::S_CHECK && baseline_valid)
      else $error("manual mode is not checking against the written baseline");
   reeval_a: assert property (restart |=> rx_idx == `TRACE_IDX_ZERO && !acc && !string_done)
      else $error("baseline or mode change did not restart the comparison");
   alarm_hold_a: assert property ($changed(trace_mismatch) |-> string_done || $past(restart))
      else $error("alarm changed without a complete string or a restart");

   learn_cov_c: cover property (state == path_trace_pkg::S_LEARN ##1 state == path_trace_pkg::S_CHECK);
   alarm_cov_c: cover property (!trace_mismatch ##1 trace_mismatch);
   clear_cov_c: cover property (trace_mismatch ##1 !trace_mismatch && string_done);
   full_cov_c: cover property (!rx_j1_ready);

endmodule // path_trace_monitor

// ---- src/path_trace_defines.svh ----
// Constants for the path trace monitor: string length, index widths, buffer depth.
// Assumes inclusion by bare name from each design file that needs them.
`ifndef PATH_TRACE_DEFINES_SVH
`define PATH_TRACE_DEFINES_SVH

`define TRACE_LEN      64
`define TRACE_IDX_W    6
`define TRACE_IDX_LAST 6'h3F
`define TRACE_IDX_ZERO 6'h00
`define RX_FIFO_DEPTH  16

`endif

// ---- src/path_trace_pkg.sv ----
// Types shared by the path trace monitor.
// Assumes nothing of its surroundings.
package path_trace_pkg;

   typedef enum logic [0:0]
   {
      S_LEARN = 1'b0,
      S_CHECK = 1'b1
   } rx_state_t;

   typedef enum logic
   {
      MODE_AUTO   = 1'b0,
      MODE_MANUAL = 1'b1
   } trace_mode_t;

endpackage

// ---- src/trace_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps

module trace_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             mclk,
   input  wire logic             nrst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp;
   logic [AW:0]      rp;
   logic [AW:0]      next_wp;
   logic [AW:0]      next_rp;
   logic             push;
   logic             pop;

   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_valid = (wp != rp);
   assign out_data  = mem[rp[AW-1:0]];
   assign next_wp   = push ? wp + (AW+1)'(1) : wp;
   assign next_rp   = pop ? rp + (AW+1)'(1) : rp;

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         wp       <= '0;
         rp       <= '0;
         in_ready <= 1'b0;
      end
      else
      begin
         wp       <= next_wp;
         rp       <= next_rp;
         // Registered so the upstream ready never depends on this cycle's pop.
         in_ready <= ((next_wp - next_rp) != (AW+1)'(DEPTH));
      end
   end

   always_ff @(posedge mclk)
   begin
      if (push)
      begin
         mem[wp[AW-1:0]] <= in_data;
      end
   end

endmodule // trace_fifo

// ---- sim/far_end.sv ----
// Model of the remote path-terminating element: sends J1 strings, records J1 bytes sent to it.
// Assumes valid/ready receive handshake and the one-cycle transmit byte strobe of the monitor.
`timescale 1ns/1ps

module far_end (
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic       rx_j1_ready,
   input  wire logic [7:0] tx_byte,
   input  wire logic       tx_byte_valid,
   output logic            rx_j1_valid,
   output logic [7:0]      rx_j1_byte
);
   logic [7:0] seen [$];

   initial
   begin
      rx_j1_valid = 1'b0;
      rx_j1_byte  = 8'h00;
   end

   always @(posedge mclk)
      if (nrst && tx_byte_valid === 1'b1)
         seen.push_back(tx_byte);

   // When idle the data line shows the inverse of the last byte, so stale data never matches.
   task automatic send(input logic [7:0] s [64], input int gap);
      @(posedge mclk);
      for (int k = 0; k < 64; k++)
      begin
         rx_j1_valid <= 1'b1;
         rx_j1_byte  <= s[k];
         @(posedge mclk);
         while (rx_j1_ready !== 1'b1)
            @(posedge mclk);
         if (gap > 0)
         begin
            rx_j1_valid <= 1'b0;
            rx_j1_byte  <= ~s[k];
            repeat (gap) @(posedge mclk);
         end
      end
      rx_j1_valid <= 1'b0;
      rx_j1_byte  <= ~s[63];
   endtask
endmodule // far_end

// ---- sim/tb_top.sv ----
// Self-checking bench for the path trace monitor.
// Assumes the far_end model on the receive and transmit sides.
`timescale 1ns/1ps
`include "path_trace_defines.svh"

module tb_top;
   logic                    mclk, nrst, tx_cfg_wr, tx_slot, manual_mode, base_wr;
   logic [`TRACE_IDX_W-1:0] tx_cfg_addr, base_addr;
   logic [7:0]              tx_cfg_data, base_data, tx_byte, rx_j1_byte;
   logic                    tx_byte_valid, rx_j1_valid, rx_j1_ready;
   logic                    baseline_valid, trace_mismatch, string_done;
   logic [7:0]              pa [64], pb [64], pc [64];
   int                      bad_count = 0, n_tests = 0;

   path_trace_monitor path_trace_monitor_i (.mclk, .nrst, .tx_cfg_wr, .tx_cfg_addr, .tx_cfg_data,
      .tx_slot, .tx_byte, .tx_byte_valid, .rx_j1_valid, .rx_j1_byte, .rx_j1_ready, .manual_mode,
      .base_wr, .base_addr, .base_data, .baseline_valid, .trace_mismatch, .string_done);
   far_end far_end_i (.mclk, .nrst, .rx_j1_ready, .tx_byte, .tx_byte_valid, .rx_j1_valid, .rx_j1_byte);

   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task automatic chk1(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e)
      begin
         bad_count++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wait_done();
      int n;
      for (n = 0; n < 600; n++)
      begin
         @(posedge mclk);
         #1;
         if (string_done === 1'b1)
            break;
      end
      chk1("string_done", 1'b1, string_done);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Back-to-back slots across the wrap point.
   task automatic tx_test();
      for (int k = 0; k < 64; k++)
      begin
         @(posedge mclk);
         tx_cfg_wr   <= 1'b1;
         tx_cfg_addr <= k[5:0];
         tx_cfg_data <= pa[k];
      end
      @(posedge mclk);
      tx_cfg_wr <= 1'b0;
      tx_slot   <= 1'b1;
      repeat (66) @(posedge mclk);
      tx_slot <= 1'b0;
      repeat (3) @(posedge mclk);
      chk8("tx_count", 8'h42, 8'(far_end_i.seen.size()));
      chk1("tx_byte_valid", 1'b0, tx_byte_valid);
      chk8("tx_byte_hold", pa[1], tx_byte);
      for (int k = 0; k < 66; k++)
         chk8("tx_byte", pa[k % 64], far_end_i.seen[k]);
   endtask

   task automatic auto_test();
      chk1("baseline_valid", 1'b0, baseline_valid);
      far_end_i.send(pa, 0);
      repeat (3) @(posedge mclk);
      chk1("baseline_valid", 1'b1, baseline_valid);
      fork far_end_i.send(pa, 2); wait_done(); join
      chk1("mismatch", 1'b0, trace_mismatch);
      fork far_end_i.send(pc, 0); wait_done(); join
      chk1("mismatch", 1'b1, trace_mismatch);
      fork far_end_i.send(pa, 1); wait_done(); join
      chk1("mismatch", 1'b0, trace_mismatch);
   endtask

   // Baseline writes stall the drain, so the buffer fills while the string arrives.
   task automatic manual_test();
      @(posedge mclk);
      manual_mode <= 1'b1;
      fork
         far_end_i.send(pb, 0);
         begin
            for (int k = 0; k < 64; k++)
            begin
               @(posedge mclk);
               base_wr   <= 1'b1;
               base_addr <= k[5:0];
               base_data <= pb[k];
               if (k == 40)
                  chk1("rx_j1_ready", 1'b0, rx_j1_ready);
            end
            @(posedge mclk);
            base_wr <= 1'b0;
            wait_done();
         end
      join
      chk1("mismatch", 1'b0, trace_mismatch);
      fork far_end_i.send(pa, 1); wait_done(); join
      chk1("mismatch", 1'b1, trace_mismatch);
      @(posedge mclk);
      manual_mode <= 1'b0;
      repeat (3) @(posedge mclk);
      chk1("mismatch", 1'b0, trace_mismatch);
      chk1("baseline_valid", 1'b0, baseline_valid);
   endtask

   initial
   begin
      {nrst, tx_cfg_wr, tx_slot, manual_mode, base_wr} = 5'h00;
      {tx_cfg_addr, base_addr, tx_cfg_data, base_data} = 28'h0;
      for (int k = 0; k < 64; k++)
      begin
         pa[k] = 8'h40 + 8'(k);
         pb[k] = 8'hC3 - 8'(k);
         pc[k] = pa[k];
      end
      pc[63] = pa[63] ^ 8'h01;
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      repeat (2) @(posedge mclk);
      tx_test();
      auto_test();
      manual_test();
      print_verdict();
   end

   // A run of all scenarios needs roughly 900 cycles.
   initial
   begin
      #40000;
      bad_count++;
      print_verdict();
   end
endmodule // tb_top
